// ==== verilog/ldm_pkg.sv ====
// Package with the constants and types of the display-mode and power control.
package ldm_pkg;

  // Register byte offsets on the APB.
  localparam logic [7:0] DISP_CTRL_OFS  = 8'h00;
  localparam logic [7:0] DH_POS_OFS     = 8'h04;
  localparam logic [7:0] DRIVE_CFG_OFS  = 8'h08;
  localparam logic [7:0] POWER_CTRL_OFS = 8'h0c;
  localparam logic [7:0] OSC_START_OFS  = 8'h10;
  localparam logic [7:0] STATUS_OFS     = 8'h14;

  // Display control fields.
  localparam int DH_EN_BIT  = 0;
  localparam int REV_BIT    = 1;
  localparam int DISP_ON_BIT = 2;
  localparam int CENTRE_BIT = 3;
  // Position fields: start in [6:0], end in [14:8].
  localparam int DH_END_LSB = 8;
  // Drive configuration fields: duty [3:0], bias [6:4], boost [9:8].
  localparam int BIAS_LSB   = 4;
  localparam int BOOST_LSB  = 8;
  localparam int CONTRAST_LSB = 16;
  // Power control fields: sleep, standby, amp level [5:4].
  localparam int SLEEP_BIT   = 0;
  localparam int STANDBY_BIT = 1;
  localparam int AMP_LSB     = 4;

  // Values after reset.
  localparam logic [3:0] DUTY_RST  = 4'he;
  localparam logic [2:0] BIAS_RST  = 3'h0;
  localparam logic [1:0] BOOST_RST = 2'h2;
  localparam logic [1:0] AMP_RST   = 2'h0;

  // Documented field codes.
  localparam logic [3:0] DUTY_120 = 4'he;
  localparam logic [3:0] DUTY_16  = 4'h1;
  localparam logic [2:0] BIAS_11  = 3'h0;
  localparam logic [2:0] BIAS_5   = 3'h6;
  localparam logic [1:0] BOOST_X6 = 2'h2;
  localparam logic [1:0] BOOST_X2 = 2'h0;
  localparam logic [1:0] AMP_OFF  = 2'h0;

  // Panel geometry and rates.
  localparam int PANEL_ROWS    = 128;
  localparam int FULL_ROWS     = 120;
  localparam int OSC_HZ        = 70000;
  localparam int FRAME_HZ      = 68;
  localparam int SYS_HZ        = 10000000;
  // Oscillator tick divider: system cycles per tick, rounded down, so the period is never longer.
  localparam int OSC_DIV       = SYS_HZ / OSC_HZ;
  // Oscillator ticks per frame, split over the active rows.
  localparam int TICKS_FRAME   = OSC_HZ / FRAME_HZ;
  // Oscillator start-up wait in ticks.
  localparam int OSC_SETTLE    = 16;

  // Power state machine.
  typedef enum logic [1:0] {
    LDM_ACTIVE  = 2'b00,
    LDM_SLEEP   = 2'b01,
    LDM_STANDBY = 2'b10
  } ldm_pwr_e;

endpackage

// ==== verilog/ldm_osc_gen.sv ====
// Internal oscillator tick generator with stop and start-up settling.
`timescale 1ns/1ps
module ldm_osc_gen
  import ldm_pkg::*;
#(
  parameter int DIV = OSC_DIV
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Control.
  input  wire logic run_i,
  // Status.
  output logic      tick_o,
  output logic      stable_o
);

  logic [15:0] div_r;  // Divider count.
  logic [4:0]  set_r;  // Settling tick count.
  logic        wrap;   // Divider terminal count.

  assign wrap   = (div_r == 16'(DIV - 1));
  assign tick_o = run_i & wrap;

  // Divider runs only while the oscillator is enabled.
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !run_i) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= wrap ? 16'h0000 : div_r + 16'h0001;
    end
  end

  // Stable after a fixed number of ticks since the start.
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !run_i) begin
      set_r <= 5'h00;
    end else if (tick_o && set_r != 5'(OSC_SETTLE)) begin
      set_r <= set_r + 5'h01;
    end
  end

  assign stable_o = (set_r == 5'(OSC_SETTLE));

endmodule // ldm_osc_gen

// ==== verilog/ldm_row_map.sv ====
// Maps a panel row to its stored raster-row under double height.
`timescale 1ns/1ps
module ldm_row_map
  import ldm_pkg::*;
(
  // Settings.
  input  wire logic       dh_en_i,
  input  wire logic [6:0] start_i,
  input  wire logic [6:0] end_i,
  // Row in and out.
  input  wire logic [6:0] panel_row_i,
  output logic [6:0]      src_row_o,
  output logic            in_dh_o
);

  logic [6:0] off;  // Offset into the doubled range.

  // Range is in panel rows, so scrolling never moves it.
  assign in_dh_o = dh_en_i && panel_row_i >= start_i
                   && panel_row_i <= end_i;
  assign off = panel_row_i - start_i;
  // Each source row from the start shows on two panel rows.
  assign src_row_o = in_dh_o ? start_i + {1'b0, off[6:1]}
                             : panel_row_i;

endmodule // ldm_row_map

// ==== verilog/ldm_ctrl.sv ====
// Display-mode and power-mode control with its APB register file.
`timescale 1ns/1ps
module ldm_ctrl
  import ldm_pkg::*;
#(
  parameter int ROWS = PANEL_ROWS
) (
  // Clock and reset.
  input  wire logic        SYS_CLK_I,
  input  wire logic        RSTN_I,
  // APB slave.
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Pixel path: stored pixel in, drive level out.
  input  wire logic        PIXEL_I,
  output logic             PIXEL_O,
  // Row scan toward the common and segment drivers.
  output logic [6:0]       PANEL_ROW_O,
  output logic [6:0]       SOURCE_ROW_O,
  output logic             ROW_SELECTED_O,
  output logic             DRIVE_ENABLE_O,
  output logic             ROW_TICK_O,
  // Analogue settings.
  output logic [3:0]       DRIVE_DUTY_SELECT_O,
  output logic [3:0]       DUTY_ROWS_LOG_O,
  output logic [2:0]       DRIVE_BIAS_SELECT_O,
  output logic [2:0]       BOOSTER_MULT_O,
  output logic [5:0]       CONTRAST_LEVEL_O,
  output logic [1:0]       AMP_POWER_LEVEL_O,
  output logic             SUPPLY_OFF_OK_O,
  output logic             OSC_RUN_O
);

  // Control registers.
  logic       dh_en_r, rev_r, disp_on_r, centre_r;
  logic [6:0] dh_start_r, dh_end_r;
  logic [3:0] duty_r;
  logic [2:0] bias_r;
  logic [1:0] boost_r, amp_r;
  logic [5:0] contrast_r;
  logic       sleep_r, standby_r, osc_on_r;
  ldm_pwr_e   pwr;

  // Scan state.
  logic [6:0]  row_r;        // Active row counter.
  logic [10:0] tick_cnt_r;   // Oscillator ticks within the row.
  logic [31:0] rdata_r;      // Registered read data.
  logic        row_tick_r;   // One-cycle row advance pulse.

  // Bus decode.
  logic wr_acc, rd_acc, hit;
  logic sel_ctrl, sel_pos, sel_drv, sel_pwr, sel_osc, sel_stat;
  logic wr_allowed;
  logic osc_tick, osc_stable;
  logic [6:0]  active_rows, win_base, row_limit;
  logic [10:0] ticks_per_row;
  logic [6:0]  src_row;
  logic        in_dh, running;

  assign sel_ctrl = PADDR_I == DISP_CTRL_OFS;
  assign sel_pos  = PADDR_I == DH_POS_OFS;
  assign sel_drv  = PADDR_I == DRIVE_CFG_OFS;
  assign sel_pwr  = PADDR_I == POWER_CTRL_OFS;
  assign sel_osc  = PADDR_I == OSC_START_OFS;
  assign sel_stat = PADDR_I == STATUS_OFS;
  assign hit = sel_ctrl | sel_pos | sel_drv | sel_pwr | sel_osc | sel_stat;
  assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_acc = PSEL_I & ~PENABLE_I & ~PWRITE_I;
  // In standby only the start-oscillation write and a power-control write
  // after the oscillator has settled are honoured.
  assign wr_allowed = !standby_r || sel_osc
                      || (sel_pwr && osc_on_r && osc_stable);
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;
  assign PRDATA_O  = rdata_r;

  // Display control and position registers.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      dh_en_r <= 1'b0; rev_r <= 1'b0; disp_on_r <= 1'b0; centre_r <= 1'b0;
      dh_start_r <= 7'h00; dh_end_r <= 7'h00;
    end else if (wr_acc && wr_allowed) begin
      if (sel_ctrl) begin
        dh_en_r   <= PWDATA_I[DH_EN_BIT];
        rev_r     <= PWDATA_I[REV_BIT];
        disp_on_r <= PWDATA_I[DISP_ON_BIT];
        centre_r  <= PWDATA_I[CENTRE_BIT];
      end
      if (sel_pos) begin
        dh_start_r <= PWDATA_I[6:0];
        dh_end_r   <= PWDATA_I[DH_END_LSB +: 7];
      end
    end
  end

  // Drive configuration register.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      duty_r <= DUTY_RST; bias_r <= BIAS_RST; boost_r <= BOOST_RST;
      contrast_r <= 6'h00;
    end else if (wr_acc && wr_allowed && sel_drv) begin
      duty_r     <= PWDATA_I[3:0];
      bias_r     <= PWDATA_I[BIAS_LSB +: 3];
      boost_r    <= PWDATA_I[BOOST_LSB +: 2];
      contrast_r <= PWDATA_I[CONTRAST_LSB +: 6];
    end
  end

  // Power control and oscillator start.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      sleep_r <= 1'b0; standby_r <= 1'b0; amp_r <= AMP_RST;
      osc_on_r <= 1'b1;
    end else if (wr_acc && wr_allowed) begin
      if (sel_pwr) begin
        sleep_r   <= PWDATA_I[SLEEP_BIT];
        standby_r <= PWDATA_I[STANDBY_BIT];
        amp_r     <= PWDATA_I[AMP_LSB +: 2];
        // Entering standby stops the oscillator.
        if (PWDATA_I[STANDBY_BIT]) osc_on_r <= 1'b0;
      end
      if (sel_osc) begin
        osc_on_r <= 1'b1;
      end
    end
  end

  // Read data is registered in the setup cycle.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_acc) begin
      rdata_r <= sel_ctrl ? {28'h0, centre_r, disp_on_r, rev_r, dh_en_r} :
                 sel_pos  ? {17'h0, dh_end_r, 1'b0, dh_start_r} :
                 sel_drv  ? {10'h0, contrast_r, 6'h0, boost_r, 1'b0,
                             bias_r, duty_r} :
                 sel_pwr  ? {26'h0, amp_r, 2'h0, standby_r, sleep_r} :
                 sel_stat ? {14'h0, osc_stable, osc_on_r, 1'b0, row_r,
                             6'h00, pwr} :
                 32'h0000_0000;
    end
  end

  assign pwr = standby_r ? LDM_STANDBY : sleep_r ? LDM_SLEEP : LDM_ACTIVE;

  ldm_osc_gen u_osc (
    .clk_i    (SYS_CLK_I),
    .rstn_i   (RSTN_I),
    .run_i    (osc_on_r),
    .tick_o   (osc_tick),
    .stable_o (osc_stable)
  );

  // Duty code n selects 8*(n+1) rows for codes up to 1110, and 1111 gives 0; 1110 is 120 and 0001 is 16.
  assign active_rows = 7'((duty_r + 4'h1) * 8);
  // Ticks per row split the frame ticks over the active rows, rounded down; 1111 divides by 0.
  assign ticks_per_row = 11'(TICKS_FRAME) / 11'(active_rows);
  // Centred window sits in the middle of the full area.
  assign win_base = centre_r ? 7'((FULL_ROWS - active_rows) / 2)
                             : 7'h00;
  assign row_limit = win_base + active_rows - 7'h01;
  // Sleep or standby halts the scan entirely.
  assign running = (pwr == LDM_ACTIVE) && osc_on_r;

  // Row scan over the active duty window.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I || !running) begin
      row_r <= 7'h00; tick_cnt_r <= 11'h000; row_tick_r <= 1'b0;
    end else begin
      row_tick_r <= 1'b0;
      if (osc_tick) begin
        if (tick_cnt_r + 11'h001 >= ticks_per_row) begin
          tick_cnt_r <= 11'h000;
          row_tick_r <= 1'b1;
          row_r <= (row_r >= row_limit || row_r < win_base) ? win_base
                   : row_r + 7'h01;
        end else begin
          tick_cnt_r <= tick_cnt_r + 11'h001;
        end
      end
    end
  end

  ldm_row_map u_map (
    .dh_en_i     (dh_en_r),
    .start_i     (dh_start_r),
    .end_i       (dh_end_r),
    .panel_row_i (row_r),
    .src_row_o   (src_row),
    .in_dh_o     (in_dh)
  );

  // Rows outside the window and all rows in a low-power mode stay dark.
  assign DRIVE_ENABLE_O = running && disp_on_r;
  assign ROW_SELECTED_O = DRIVE_ENABLE_O && row_r >= win_base
                          && row_r <= row_limit;
  // Reverse inverts lit and unlit; ground output when not driving.
  assign PIXEL_O = DRIVE_ENABLE_O & (PIXEL_I ^ rev_r);
  assign PANEL_ROW_O  = row_r;
  assign SOURCE_ROW_O = src_row;
  assign ROW_TICK_O   = row_tick_r;
  assign DRIVE_DUTY_SELECT_O = duty_r;
  assign DUTY_ROWS_LOG_O     = duty_r;
  assign DRIVE_BIAS_SELECT_O = bias_r;
  // Booster code 00 two-times, 01 five, 10 six, 11 seven.
  assign BOOSTER_MULT_O = (boost_r == BOOST_X2) ? 3'd2 :
                          (boost_r == BOOST_X6) ? 3'd6 :
                          boost_r[0] && boost_r[1] ? 3'd7 : 3'd5;
  assign CONTRAST_LEVEL_O  = contrast_r;
  assign AMP_POWER_LEVEL_O = amp_r;
  assign SUPPLY_OFF_OK_O   = (pwr != LDM_ACTIVE)
                             && (amp_r == AMP_OFF);
  assign OSC_RUN_O = osc_on_r;

  // Outputs dark whenever sleep is set.
  a_sleep_dark: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    sleep_r |-> !PIXEL_O && !ROW_SELECTED_O)
    else $error("Display drives during sleep.");

  // Standby write blocks the oscillator next cycle.
  a_standby_osc: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    wr_acc && sel_pwr && PWDATA_I[STANDBY_BIT] && wr_allowed
    |=> !OSC_RUN_O)
    else $error("Oscillator still runs in standby.");

  // A drive-config write in standby leaves the duty code unchanged.
  a_standby_ign: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    standby_r && wr_acc && sel_drv |=> $stable(duty_r))
    else $error("Instruction accepted in standby.");

  // Reverse inverts the pixel while driving.
  a_rev_pixel: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    DRIVE_ENABLE_O |-> PIXEL_O == (PIXEL_I ^ rev_r))
    else $error("Reverse video not applied.");

  // Row counter is inside the window at each row advance under a steady duty and centring.
  a_row_window: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    $rose(row_tick_r) && $stable(duty_r) && $stable(centre_r)
    |-> row_r >= win_base && row_r <= row_limit)
    else $error("Row scan left the duty window.");

  // Doubled rows map to the source two panel rows apart.
  a_dh_double: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    in_dh |-> src_row == dh_start_r + 7'((row_r - dh_start_r) >> 1))
    else $error("Double-height mapping wrong.");

  // No doubling when disabled.
  a_dh_off: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    !dh_en_r |-> src_row == row_r)
    else $error("Doubling while disabled.");

  // Supply release only in a low-power mode with amp code 00.
  a_supply_off: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    SUPPLY_OFF_OK_O |-> (sleep_r || standby_r) && amp_r == 2'h0)
    else $error("Supply release outside low power.");

  // Duty decode for the documented codes.
  a_duty_rows: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
    (duty_r == DUTY_120 |-> active_rows == 7'd120)
    and (duty_r == DUTY_16 |-> active_rows == 7'd16))
    else $error("Duty decode wrong.");

endmodule // ldm_ctrl

// ==== bench/ldm_host_model.sv ====
// Host processor model that speaks APB to the control registers.
`timescale 1ns/1ps
module ldm_host_model (
  // Clock.
  input  wire logic        clk_i,
  // APB master side.
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i
);
  // The bus is idle from time zero so the slave never sees a stray request.
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
  end

  // One transfer; called just after a rising edge, returns after one.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    n = 0;
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    // The request stands until ready is seen high at an edge.
    while (pready_i !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    q = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // One idle edge keeps two requests from colliding in one time step.
    @(posedge clk_i);
  endtask
endmodule // ldm_host_model

// ==== bench/ldm_ctrl_tb.sv ====
// Self-checking testbench of the display-mode and power control.
`timescale 1ns/1ps
module ldm_ctrl_tb
  import ldm_pkg::*;
;
  // Clock, reset and stimulus.
  logic        sys_clk;
  logic        rstn;
  logic        pixel;
  // APB wiring between host model and design.
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // Design outputs.
  logic        pix_o;
  logic [6:0]  prow;
  logic [6:0]  srow;
  logic        rsel;
  logic        dren;
  logic        rtick;
  logic [3:0]  duty;
  logic [2:0]  bias;
  logic [2:0]  boost;
  logic [5:0]  contr;
  logic [1:0]  amp;
  logic        supoff;
  logic        oscrun;
  // Scoreboard counters.
  int          mismatches;
  int          checks_done;

  ldm_ctrl dut_u (.SYS_CLK_I(sys_clk), .RSTN_I(rstn), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .PIXEL_I(pixel), .PIXEL_O(pix_o),
    .PANEL_ROW_O(prow), .SOURCE_ROW_O(srow), .ROW_SELECTED_O(rsel),
    .DRIVE_ENABLE_O(dren), .ROW_TICK_O(rtick),
    .DRIVE_DUTY_SELECT_O(duty), .DUTY_ROWS_LOG_O(),
    .DRIVE_BIAS_SELECT_O(bias), .BOOSTER_MULT_O(boost),
    .CONTRAST_LEVEL_O(contr), .AMP_POWER_LEVEL_O(amp),
    .SUPPLY_OFF_OK_O(supoff), .OSC_RUN_O(oscrun));

  ldm_host_model host_u (.clk_i(sys_clk), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr));

  // Free-running 10 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever begin
      #50 sys_clk = ~sys_clk;
    end
  end

  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Register write and read through the host model.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    host_u.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] q;
    logic        e;
    host_u.xfer(1'b0, a, 32'h0, q, e);
    chk("read data", ex, q);
  endtask

  // Reference row mapping: each stored row shown on two panel rows.
  function automatic logic [6:0] ref_src(input logic dh,
      input logic [6:0] s, input logic [6:0] e, input logic [6:0] r);
    if (dh && r >= s && r <= e) begin
      ref_src = s + ((r - s) >> 1);
    end else begin
      ref_src = r;
    end
  endfunction

  // Reset values and an unmapped access.
  task automatic t_reset;
    logic [31:0] q;
    logic        e;
    rd(DRIVE_CFG_OFS, 32'h0000_020e);
    rd(POWER_CTRL_OFS, 32'h0);
    chk("osc run", 1, oscrun);
    host_u.xfer(1'b0, 8'h18, 32'h0, q, e);
    chk("unmapped data", 0, q);
    chk("unmapped err", 1, e);
  endtask

  // Every booster code, with the partial-display duty and bias codes.
  task automatic t_codes;
    logic [2:0] mult [4];
    mult = '{3'h2, 3'h5, 3'h6, 3'h7};
    for (int b = 0; b < 4; b++) begin
      wr(DRIVE_CFG_OFS, {10'h0, 6'h2a, 6'h0, 2'(b), 8'h61});
      chk("duty", DUTY_16, duty);
      chk("bias", BIAS_5, bias);
      chk("boost", mult[b], boost);
      chk("contrast", 6'h2a, contr);
    end
    wr(DRIVE_CFG_OFS, 32'h0000_020e);
    chk("duty", DUTY_120, duty);
    chk("bias", BIAS_11, bias);
    chk("boost", 3'h6, boost);
  endtask

  // Reverse video over all pixel and reverse combinations.
  task automatic t_reverse;
    for (int v = 0; v < 4; v++) begin
      wr(DISP_CTRL_OFS, {29'h0, 1'b1, v[1], 1'b0});
      pixel <= v[0];
      @(posedge sys_clk);
      chk("drive", 1, dren);
      chk("pixel", v[0] ^ v[1], pix_o);
    end
  endtask

  // Reduced duty window at the top and at the centre.
  task automatic t_window;
    int lo;
    int n;
    // Display off while the duty and boost change, then back on.
    wr(DISP_CTRL_OFS, 32'h0);
    wr(DRIVE_CFG_OFS, 32'h0000_0061);
    for (int k = 0; k < 4; k++) begin
      wr(DISP_CTRL_OFS, k[0] ? 32'hc : 32'h4);
      // Wait for a row advance so the scan has entered the new window.
      n = 0;
      while (rtick !== 1'b1 && n < 20000) begin
        @(posedge sys_clk);
        n++;
      end
      chk("row tick", 1, rtick);
      lo = k[0] ? (FULL_ROWS - 16) / 2 : 0;
      chk("row sel", (prow >= lo) && (prow < lo + 16), rsel);
    end
    wr(DRIVE_CFG_OFS, 32'h0000_020e);
  endtask

  // Double height around the row now scanned.
  task automatic t_dheight;
    logic [6:0] s;
    logic [6:0] e;
    e = prow;
    s = e >> 1;
    wr(DH_POS_OFS, {17'h0, e, 1'b0, s});
    wr(DISP_CTRL_OFS, 32'h5);
    chk("src row", ref_src(1'b1, s, e, prow), srow);
    wr(DISP_CTRL_OFS, 32'h4);
    chk("src row off", prow, srow);
  endtask

  // Sleep with the supply levels.
  task automatic t_sleep;
    pixel <= 1'b1;
    wr(POWER_CTRL_OFS, 32'h1);
    chk("drive", 0, dren);
    chk("row sel", 0, rsel);
    chk("pixel", 0, pix_o);
    chk("osc run", 1, oscrun);
    chk("supply off", 1, supoff);
    wr(POWER_CTRL_OFS, 32'h11);
    chk("supply off", 0, supoff);
    rd(STATUS_OFS, 32'h0003_0001 | {17'h0, prow, 8'h0});
    wr(POWER_CTRL_OFS, 32'h0);
  endtask

  // Standby entry, refused writes and the exit sequence.
  task automatic t_standby;
    logic [31:0] q;
    logic        e;
    int          n;
    wr(POWER_CTRL_OFS, 32'h2);
    chk("osc run", 0, oscrun);
    chk("drive", 0, dren);
    chk("supply off", 1, supoff);
    wr(DISP_CTRL_OFS, 32'h0);
    rd(DISP_CTRL_OFS, 32'h4);
    wr(POWER_CTRL_OFS, 32'h0);
    rd(POWER_CTRL_OFS, 32'h2);
    wr(OSC_START_OFS, 32'h1);
    chk("osc run", 1, oscrun);
    n = 0;
    q = 32'h0;
    while (q[17] !== 1'b1 && n < 1500) begin
      host_u.xfer(1'b0, STATUS_OFS, 32'h0, q, e);
      n++;
    end
    chk("osc stable", 1, q[17]);
    wr(POWER_CTRL_OFS, 32'h0);
    rd(POWER_CTRL_OFS, 32'h0);
    chk("drive", 1, dren);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence: reset for ten cycles, then every scenario.
  initial begin
    mismatches = 0;
    checks_done = 0;
    rstn = 1'b0;
    pixel = 1'b0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_codes();
    t_reverse();
    t_window();
    t_dheight();
    t_sleep();
    t_standby();
    give_verdict();
  end

  // Watchdog cuts a hang short well past the expected run length.
  initial begin
    repeat (90000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end
endmodule // ldm_ctrl_tb
